//--- rtl/wdt_sleep_aware.sv
`timescale 1ns/1ps
`include "wdt_map.svh"
// What this block does
// - Sleep entry zeroes counter, runs if enabled
// - Sleep exit zeroes counter again
// - Timeout in Sleep wakes, no reset
// - Wake timeout updates timeout and powerdown flags
// - Watchdog reset cause flag records trigger
// - Counter held clear when disabled
// - Awake-only mode clears and stops in Sleep
// - Oscillator divider change leaves counter alone
// - Period code selects 1:32 doubling ratios
// - Reserved period codes act as 1:32
// - Period resets to code 01011
// - Soft enable matters only in mode 01
// - Prescaler counts low-frequency oscillator cycles
// - Control bits 7 and 6 read zero
// - Mode 11 always, 10 awake, 00 off
// - Reset, clear instruction, oscillator fail clear counter
// - Awake timeout resets the device
module wdt_sleep_aware
  import wdt_pkg::*;
#(
  parameter int COUNT_W = `COUNT_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core and power management
  input wire logic lowFreqOsc,
  input wire logic [1:0] wdModeConfig,
  input wire wdt_pkg::core_req_t coreReq,
  input wire logic intOscDivChange,
  output logic wdResetReq,
  output logic wakeReq,
  output wdt_pkg::pwr_flags_t pwrFlags,
  output logic irq
);
  import wdt_pkg::*;

  logic lfTick; // One pulse per slow-oscillator cycle
  logic [COUNT_W-1:0] count_q; // Prescale counter
  logic [4:0] period_q; // Period select field
  logic softEnable_q; // Software enable
  logic asleep_q; // Device sleeping
  logic [`EV_COUNT-1:0] status_q; // Sticky events
  logic [`EV_COUNT-1:0] mask_q; // Interrupt mask
  logic wdActive; // Watchdog counting now
  logic hitLimit; // Counter at selected ratio
  logic timeout; // Timeout this cycle
  logic aPhase_q; // Data phase pending
  logic aWrite_q;
  logic [11:0] aAddr_q;
  wd_mode_t mode;
  logic rdTake; // Read accepted at this edge
  logic [31:0] rdWord; // Word of the register being addressed

  // Ratio minus one for a period code; reserved codes fall to 1:32
  function automatic logic [COUNT_W-1:0] limitOf(input logic [4:0] code);
    logic [4:0] c;
    c = (code > `PERIOD_MAX_CODE) ? 5'h00 : code;
    limitOf = COUNT_W'((64'h1 << (c + `PERIOD_SHIFT_BASE)) - 64'h1);
  endfunction : limitOf

  wdt_lf_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .lowFreqOsc(lowFreqOsc),
    .tick(lfTick)
  );

  assign mode = wd_mode_t'(wdModeConfig);

  // Mode decode; soft enable only counts in software mode
  always_comb
  begin
    unique case (mode)
      MODE_ALWAYS_E: wdActive = 1'b1;
      MODE_AWAKE_E: wdActive = ~asleep_q;
      MODE_SOFT_E: wdActive = softEnable_q;
      MODE_OFF_E: wdActive = 1'b0;
    endcase
  end

  assign hitLimit = (count_q >= limitOf(period_q));
  assign timeout = wdActive & lfTick & hitLimit;

  // Sleep state follows the core's entry and exit strobes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      asleep_q <= 1'b0;
    else if (coreReq.sleepEnter)
      asleep_q <= 1'b1;
    else if (coreReq.sleepExit || (timeout && asleep_q))
      asleep_q <= 1'b0;
  end

  // Prescale counter; divider changes are deliberately not an input here
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      count_q <= '0;
    else if (!wdActive)
      count_q <= '0;
    else if (coreReq.clearWatchdogInstr || coreReq.oscFail)
      count_q <= '0;
    else if (coreReq.sleepEnter)
      count_q <= '0;
    else if (coreReq.sleepExit)
      count_q <= '0;
    else if (lfTick)
      count_q <= hitLimit ? '0 : count_q + 1'b1;
  end

  // Reset request and wake request, one cycle each
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wdResetReq <= 1'b0;
      wakeReq <= 1'b0;
    end
    else
    begin
      wdResetReq <= timeout & ~asleep_q;
      wakeReq <= timeout & asleep_q;
    end
  end

  // Power flags: sleep entry sets PD low, TO high; timeouts drive TO low, an awake one only when no sleep entry or clear comes with it
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pwrFlags <= 3'b111;
    else
    begin
      if (timeout && asleep_q)
      begin
        pwrFlags.timeoutFlagN <= 1'b0;
        pwrFlags.powerdownFlagN <= 1'b0;
      end
      else if (coreReq.sleepEnter)
      begin
        pwrFlags.timeoutFlagN <= 1'b1;
        pwrFlags.powerdownFlagN <= 1'b0;
      end
      else if (coreReq.clearWatchdogInstr)
      begin
        pwrFlags.timeoutFlagN <= 1'b1;
        pwrFlags.powerdownFlagN <= 1'b1;
      end
      else if (timeout)
        pwrFlags.timeoutFlagN <= 1'b0;
      if (timeout)
        pwrFlags.wdResetCauseN <= 1'b0;
    end
  end

  // AHB-Lite address phase capture; always zero wait states
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      aPhase_q <= 1'b0;
      aWrite_q <= 1'b0;
      aAddr_q <= '0;
    end
    else if (hready)
    begin
      aPhase_q <= hsel & htrans[1];
      aWrite_q <= hwrite;
      aAddr_q <= haddr[11:0];
    end
  end

  // Control register writes; reserved bits never stored
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      period_q <= `CTL_PERIOD_RESET;
      softEnable_q <= `CTL_ENABLE_RESET;
      mask_q <= '0;
    end
    else if (aPhase_q && aWrite_q)
    begin
      if (aAddr_q == `ADDR_CONTROL)
      begin
        period_q <= hwdata[`CTL_PERIOD_MSB:`CTL_PERIOD_LSB];
        softEnable_q <= hwdata[`CTL_ENABLE_BIT];
      end
      if (aAddr_q == `ADDR_MASK)
        mask_q <= hwdata[`EV_COUNT-1:0];
    end
  end

  assign rdTake = hready & hsel & htrans[1] & ~hwrite;

  // Sticky events; cleared at the edge that captures the read word, so an
  // event landing on that same edge is kept for the next read
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      status_q <= '0;
    else
    begin
      status_q <= ((rdTake && haddr[11:0] == `ADDR_STATUS) ? '0 : status_q)
                  | {timeout & asleep_q, timeout & ~asleep_q};
    end
  end

  // Word for the addressed register; unused bits stay zero
  always_comb
  begin
    rdWord = 32'h0000_0000;
    unique case (haddr[11:0])
      `ADDR_CONTROL:
      begin
        rdWord[`CTL_PERIOD_MSB:`CTL_PERIOD_LSB] = period_q;
        rdWord[`CTL_ENABLE_BIT] = softEnable_q;
      end
      `ADDR_STATUS:
      begin
        rdWord[`EV_COUNT-1:0] = status_q;
        rdWord[`STAT_TO_N_BIT] = pwrFlags.timeoutFlagN;
        rdWord[`STAT_PD_N_BIT] = pwrFlags.powerdownFlagN;
        rdWord[`STAT_WD_RESET_CAUSE_N_N_BIT] = pwrFlags.wdResetCauseN;
      end
      `ADDR_MASK: rdWord[`EV_COUNT-1:0] = mask_q;
      `ADDR_MODE: rdWord[1:0] = wdModeConfig;
      `ADDR_COUNT: rdWord[COUNT_W-1:0] = count_q;
      default: rdWord = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address edge, so it stands for the data phase
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (rdTake)
      hrdata <= rdWord;
    else
      hrdata <= 32'h0000_0000;
  end

  // Zero wait states and OKAY; kept as flops so every output is registered
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(status_q & mask_q);
  end

  // Assertions
  property p_awake_reset;
    @(posedge clk_sys) disable iff (rst)
    (timeout && !asleep_q) |=> wdResetReq && !wakeReq;
  endproperty
  a_awake_reset: assert property (p_awake_reset) else $error("awake timeout no reset");

  property p_sleep_wake;
    @(posedge clk_sys) disable iff (rst)
    (timeout && asleep_q) |=> wakeReq && !wdResetReq && !pwrFlags.timeoutFlagN;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep timeout wrong");

  property p_off_clear;
    @(posedge clk_sys) disable iff (rst)
    (mode == MODE_OFF_E) |=> count_q == '0;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("counter runs when off");

  property p_soft_clear;
    @(posedge clk_sys) disable iff (rst)
    (mode == MODE_SOFT_E && !softEnable_q) |=> count_q == '0;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft disabled runs");

  property p_enter_clear;
    @(posedge clk_sys) disable iff (rst)
    coreReq.sleepEnter |=> count_q == '0;
  endproperty
  a_enter_clear: assert property (p_enter_clear) else $error("sleep entry no clear");

  property p_exit_clear;
    @(posedge clk_sys) disable iff (rst)
    coreReq.sleepExit && !coreReq.sleepEnter |=> count_q == '0;
  endproperty
  a_exit_clear: assert property (p_exit_clear) else $error("sleep exit no clear");

  property p_cause;
    @(posedge clk_sys) disable iff (rst)
    timeout |=> !pwrFlags.wdResetCauseN;
  endproperty
  a_cause: assert property (p_cause) else $error("cause flag not set");

  property p_limit;
    @(posedge clk_sys) disable iff (rst)
    (period_q > `PERIOD_MAX_CODE && wdActive && lfTick && count_q >= COUNT_W'(`PERIOD_MIN_LIMIT))
      |=> count_q == '0 && (wdResetReq || wakeReq);
  endproperty
  a_limit: assert property (p_limit) else $error("reserved code not 1:32");

  property p_ctrl_read;
    @(posedge clk_sys) disable iff (rst)
    (aPhase_q && !aWrite_q && aAddr_q == `ADDR_CONTROL) |-> hrdata[7:6] == 2'b00;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("reserved bits nonzero");
endmodule : wdt_sleep_aware

//--- rtl/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Register byte addresses
`define ADDR_CONTROL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_MASK 12'h008
`define ADDR_MODE 12'h00C
`define ADDR_COUNT 12'h010

// Control field layout
`define CTL_ENABLE_BIT 0
`define CTL_PERIOD_LSB 1
`define CTL_PERIOD_MSB 5
`define CTL_PERIOD_RESET 5'h0B
`define CTL_ENABLE_RESET 1'h0
`define CTL_WRITE_MASK 8'h3E

// Period codes
`define PERIOD_MAX_CODE 5'h12
`define PERIOD_SHIFT_BASE 5'h05
`define PERIOD_MIN_LIMIT 31

// Status / interrupt bits
`define EV_TIMEOUT_RESET 0
`define EV_TIMEOUT_WAKE 1
`define EV_COUNT 2

// Mode field values
`define MODE_OFF 2'h0
`define MODE_SOFT 2'h1
`define MODE_AWAKE 2'h2
`define MODE_ALWAYS 2'h3

// Power control status bit positions in the status word
`define STAT_TO_N_BIT 8
`define STAT_PD_N_BIT 9
`define STAT_WD_RESET_CAUSE_N_N_BIT 10

// Low-frequency oscillator rate and prescale counter width
`define LFOSC_HZ 31000
`define COUNT_W 23

`endif

//--- rtl/wdt_pkg.sv
package wdt_pkg;
  // Watchdog operating modes from the configuration field
  typedef enum logic [1:0] {
    MODE_OFF_E = 2'h0,
    MODE_SOFT_E = 2'h1,
    MODE_AWAKE_E = 2'h2,
    MODE_ALWAYS_E = 2'h3
  } wd_mode_t;

  // Requests from the processor core
  typedef struct packed {
    logic clearWatchdogInstr;
    logic sleepEnter;
    logic sleepExit;
    logic oscFail;
  } core_req_t;

  // Power-control flags, all active low
  typedef struct packed {
    logic timeoutFlagN;
    logic powerdownFlagN;
    logic wdResetCauseN;
  } pwr_flags_t;
endpackage : wdt_pkg

//--- rtl/wdt_lf_sync.sv
`timescale 1ns/1ps
// Turns the slow oscillator into a one-cycle tick on clk_sys
module wdt_lf_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Slow oscillator level
  input wire logic lowFreqOsc,
  // Rising-edge tick
  output logic tick
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // Two-stage synchroniser; only sync_q feeds the edge detector
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      meta_q <= lowFreqOsc;
      sync_q <= meta_q;
      last_q <= sync_q;
      tick <= sync_q & ~last_q;
    end
  end
endmodule : wdt_lf_sync

//--- tb/wdt_core_model.sv
`timescale 1ns/1ps
// Core side: slow oscillator, mode pins and one-cycle requests
module wdt_core_model
  import wdt_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // To the watchdog
  output logic lowFreqOsc,
  output logic [1:0] wdModeConfig,
  output wdt_pkg::core_req_t coreReq
);
  int ph = 0; // Half-period counter
  // Known levels before the first edge
  initial
  begin
    lowFreqOsc = 1'b0;
    wdModeConfig = 2'h0;
    coreReq = '0;
  end
  // Oscillator runs free; sped up to 16 clocks a cycle so runs stay short
  always @(posedge clk_sys)
  begin
    ph <= (ph + 1) % 8;
    if (ph == 7)
      lowFreqOsc <= ~lowFreqOsc;
  end
  // Mode pins change just after an edge
  task mode(input logic [1:0] m);
    @(posedge clk_sys);
    wdModeConfig <= m;
  endtask : mode
  // One-cycle request, bits: clear, enter, exit, fail
  task pulse(input logic [3:0] r);
    @(posedge clk_sys);
    coreReq <= r;
    @(posedge clk_sys);
    coreReq <= '0;
  endtask : pulse
endmodule : wdt_core_model

//--- tb/watchdog_timer_sleep_aware_bench.sv
`timescale 1ns/1ps
`include "wdt_map.svh"
// Self-checking bench: a table of modes against a reference model
module watchdog_timer_sleep_aware_bench;
  import wdt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, intOscDivChange = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, lowFreqOsc, wdResetReq, wakeReq, irq;
  logic [1:0] wdModeConfig;
  core_req_t coreReq;
  pwr_flags_t pwrFlags;
  int bad_count = 0, total_checks = 0, seed = 32'hc6f0;
  int n, t, ev, exT, c, seen = 0;
  // Rows: mode, control word, sleep, event (0 none, 1 reset, 2 wake)
  int rm[10] = '{3, 3, 3, 0, 1, 1, 2, 3, 1, 2};
  int rc[10] = '{0, 2, 0, 1, 0, 1, 0, 0, 1, 0};
  int rs[10] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 0};
  int re[10] = '{1, 1, 1, 0, 0, 1, 0, 2, 2, 1};

  wdt_sleep_aware DUT (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lowFreqOsc(lowFreqOsc),
    .wdModeConfig(wdModeConfig), .coreReq(coreReq), .intOscDivChange(intOscDivChange),
    .wdResetReq(wdResetReq), .wakeReq(wakeReq), .pwrFlags(pwrFlags), .irq(irq));

  wdt_core_model CORE (.clk_sys(clk_sys), .lowFreqOsc(lowFreqOsc),
    .wdModeConfig(wdModeConfig), .coreReq(coreReq));

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;
  // Divider pin toggles at random; the count must not notice
  always @(posedge clk_sys)
    intOscDivChange <= 1'($random(seed));
  // Counts every timeout the design reports
  always @(posedge clk_sys)
    if (wdResetReq || wakeReq)
      seen <= seen + 1;

  // Single AHB-Lite word transfer; read data taken at the data-phase edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {20'h0, a};
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
      @(posedge clk_sys);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Verdict and end of run
  task stop_test;
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Hang guard, well beyond the roughly 8k cycles the tests need
  initial
  begin
    #200000;
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, `ADDR_CONTROL, 32'h0);
    chk(rd, 32'h16);
    bus(1'b1, `ADDR_CONTROL, 32'hFF);
    bus(1'b0, `ADDR_CONTROL, 32'h0);
    chk(rd, 32'h3F);
    // Unmapped place reads zero
    bus(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    // Random reserved period code
    rc[2] = (19 + $unsigned($random(seed)) % 13) << 1;
    for (int r = 0; r < 10; r++)
    begin
      CORE.mode(2'(rm[r]));
      bus(1'b1, `ADDR_MASK, (r % 2) ? 32'h3 : 32'h0);
      bus(1'b1, `ADDR_CONTROL, 32'(rc[r]));
      CORE.pulse(4'h8);
      if (rs[r])
        CORE.pulse(4'h4);
      // Model: ratio doubles per code, reserved codes act as the minimum
      c = (rc[r] >> 1) & 31;
      exT = (c > 18) ? 32 : (1 << (c + 5));
      for (n = 0; n < (exT + 4) * 16 && !wdResetReq && !wakeReq; n++)
        @(posedge clk_sys);
      ev = wdResetReq ? 1 : (wakeReq ? 2 : 0);
      chk(ev, re[r]);
      if (ev != 0)
      begin
        t = (n + 8) / 16;
        chk(((t - exT) * (t - exT) <= 1) ? exT : t, exT);
        repeat (2) @(posedge clk_sys);
        chk(irq, r % 2);
        bus(1'b0, `ADDR_STATUS, 32'h0);
        chk(rd & 32'h703, (ev == 1) ? 32'h201 : 32'h002);
        chk({29'h0, pwrFlags}, (ev == 1) ? 32'h2 : 32'h0);
        repeat (2) @(posedge clk_sys);
        chk(irq, 0);
      end
      CORE.mode(2'h0);
    end
    // Clear, Sleep entry, Sleep exit and oscillator fail each restart the count
    CORE.mode(2'h3);
    bus(1'b0, `ADDR_MODE, 32'h0);
    chk(rd, 32'h3);
    bus(1'b1, `ADDR_CONTROL, 32'h0);
    CORE.pulse(4'h8);
    n = seen;
    for (int k = 0; k < 4; k++)
    begin
      repeat (320) @(posedge clk_sys);
      CORE.pulse(4'h8 >> k);
      bus(1'b0, `ADDR_COUNT, 32'h0);
      chk(rd >> 1, 0);
    end
    repeat (320) @(posedge clk_sys);
    chk(seen, n);
    stop_test();
  end
endmodule : watchdog_timer_sleep_aware_bench
